// file: core/dtg_generator.sv
// dual-tone dial generator: select registers, table load, test mode, tone sum
`timescale 1ns/1ns
`include "dtg_defs.svh"


module dtg_generator (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // cpu port access
    input  wire dtg_pkg::dtg_addr_type  port_addr,
    input  wire logic                   port_wr,
    input  wire logic                   port_rd,
    input  wire dtg_pkg::dtg_code_type  port_wdata,
    output dtg_pkg::dtg_code_type       port_rdata_ff,
    // table load
    input  wire logic                   table_byte_to_tone_pair,
    input  wire logic                   carry_flag,
    input  wire dtg_pkg::dtg_code_type  memory_pointer_pair_nibble,
    // tone test pins
    input  wire logic                   tone_test_mode,
    input  wire dtg_pkg::dtg_code_type  test_low_code_port,
    input  wire dtg_pkg::dtg_code_type  test_high_code_port,
    // tone output
    output dtg_pkg::dtg_tone_type       tone_level_ff,
    output logic                        tone_active_ff
);
    import dtg_pkg::*;

    // ****************************************
    // keypad table, index {carry, nibble}
    // ****************************************
    // 0..9 digits, 10 star, 11 hash, 12..15 fourth column,
    // 16..23 single tones, the rest silent
    localparam logic [7:0] TBL_ROM [32] = '{
        8'h28, 8'h11, 8'h21, 8'h41, 8'h12, 8'h22, 8'h42, 8'h14,
        8'h24, 8'h44, 8'h18, 8'h48, 8'h81, 8'h82, 8'h84, 8'h88,
        8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };

    dtg_code_type  low_group_tone_select_ff;
    dtg_code_type  high_group_tone_select_ff;
    dtg_code_type  nxt_low_sel;
    dtg_code_type  nxt_high_sel;
    logic [4:0]    tbl_index;
    logic [7:0]    tbl_byte;
    logic          test_meta_ff;
    logic          test_sync_ff;
    dtg_code_type  low_pin_meta_ff;
    dtg_code_type  low_pin_sync_ff;
    dtg_code_type  high_pin_meta_ff;
    dtg_code_type  high_pin_sync_ff;
    dtg_code_type  eff_low;
    dtg_code_type  eff_high;
    logic          low_valid;
    logic          high_valid;
    logic          low_suppress;
    logic          low_en;
    logic          high_en;
    dtg_count_type low_step;
    dtg_count_type high_step;
    dtg_level_type low_level;
    dtg_level_type high_level;
    dtg_code_type  nxt_rdata;

    // ****************************************
    // table fetch
    // ****************************************
    assign tbl_index = {carry_flag, memory_pointer_pair_nibble};
    assign tbl_byte  = TBL_ROM[tbl_index];

    // ****************************************
    // select registers
    // ****************************************
    always_comb begin
        nxt_low_sel  = low_group_tone_select_ff;
        nxt_high_sel = high_group_tone_select_ff;
        if (table_byte_to_tone_pair) begin
            nxt_low_sel  = tbl_byte[3:0];
            nxt_high_sel = tbl_byte[7:4];
        end else if (port_wr) begin
            if (port_addr == `DTG_ADDR_LOW) begin
                nxt_low_sel = port_wdata;
            end
            if (port_addr == `DTG_ADDR_HIGH) begin
                nxt_high_sel = port_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            low_group_tone_select_ff <= `DTG_LOW_RESET;
        end else begin
            low_group_tone_select_ff <= nxt_low_sel;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            high_group_tone_select_ff <= `DTG_HIGH_RESET;
        end else begin
            high_group_tone_select_ff <= nxt_high_sel;
        end
    end

    // ****************************************
    // read-back
    // ****************************************
    always_comb begin
        nxt_rdata = 4'h0;
        if (port_rd && (port_addr == `DTG_ADDR_LOW)) begin
            nxt_rdata = low_group_tone_select_ff;
        end else if (port_rd && (port_addr == `DTG_ADDR_HIGH)) begin
            nxt_rdata = high_group_tone_select_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            port_rdata_ff <= `DTG_RDATA_RESET;
        end else begin
            port_rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // test pin synchronisers
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            test_meta_ff     <= 1'b0;
            test_sync_ff     <= 1'b0;
            low_pin_meta_ff  <= 4'h0;
            low_pin_sync_ff  <= 4'h0;
            high_pin_meta_ff <= 4'h0;
            high_pin_sync_ff <= 4'h0;
        end else begin
            test_meta_ff     <= tone_test_mode;
            test_sync_ff     <= test_meta_ff;
            low_pin_meta_ff  <= test_low_code_port;
            low_pin_sync_ff  <= low_pin_meta_ff;
            high_pin_meta_ff <= test_high_code_port;
            high_pin_sync_ff <= high_pin_meta_ff;
        end
    end

    // ****************************************
    // code decode
    // ****************************************
    assign eff_low  = test_sync_ff ? low_pin_sync_ff : low_group_tone_select_ff;
    assign eff_high = test_sync_ff ? high_pin_sync_ff : high_group_tone_select_ff;

    always_comb begin
        low_step  = 12'(`DTG_STEP_CNT(`DTG_FREQ_L0_DHZ));
        low_valid = 1'b1;
        unique case (eff_low)
            4'h1: low_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_L0_DHZ));
            4'h2: low_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_L1_DHZ));
            4'h4: low_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_L2_DHZ));
            4'h8: low_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_L3_DHZ));
            default: low_valid = 1'b0;
        endcase
    end

    always_comb begin
        high_step  = 12'(`DTG_STEP_CNT(`DTG_FREQ_H0_DHZ));
        high_valid = 1'b1;
        unique case (eff_high)
            4'h1: high_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_H0_DHZ));
            4'h2: high_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_H1_DHZ));
            4'h4: high_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_H2_DHZ));
            4'h8: high_step = 12'(`DTG_STEP_CNT(`DTG_FREQ_H3_DHZ));
            default: high_valid = 1'b0;
        endcase
    end

    assign low_suppress = (eff_high == 4'hd) || (eff_high == 4'ha)
                       || (eff_high == 4'hb) || (eff_high == 4'hc);
    assign low_en  = low_valid && !low_suppress;
    assign high_en = high_valid;

    // ****************************************
    // oscillators
    // ****************************************
    dtg_tone_osc #(
        .LOW_AMP    (1'b1)
    ) u_low_osc (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .enable     (low_en),
        .step_count (low_step),
        .level_ff   (low_level)
    );

    dtg_tone_osc #(
        .LOW_AMP    (1'b0)
    ) u_high_osc (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .enable     (high_en),
        .step_count (high_step),
        .level_ff   (high_level)
    );

    // ****************************************
    // tone sum
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tone_level_ff <= `DTG_TONE_IDLE;
        end else begin
            tone_level_ff <= {1'b0, low_level} + {1'b0, high_level};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tone_active_ff <= 1'b0;
        end else begin
            tone_active_ff <= low_en || high_en;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking gen_cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_table_load;
        table_byte_to_tone_pair;
    endsequence

    sequence s_both_loaded(logic [7:0] b);
        (low_group_tone_select_ff == b[3:0]) && (high_group_tone_select_ff == b[7:4]);
    endsequence

    a_low_write_store: assert property (
        port_wr && !table_byte_to_tone_pair && (port_addr == `DTG_ADDR_LOW)
        |=> low_group_tone_select_ff == $past(port_wdata))
        else $error("low select write not stored");

    a_high_read_back: assert property (
        port_rd && (port_addr == `DTG_ADDR_HIGH)
        |=> port_rdata_ff == $past(high_group_tone_select_ff))
        else $error("high select read-back wrong");

    a_table_nibble_split: assert property (
        s_table_load |=> s_both_loaded($past(TBL_ROM[{carry_flag,
                                                       memory_pointer_pair_nibble}])))
        else $error("table byte not split into both selects");

    a_no_single_gap: assert property (
        s_table_load ##1 (low_en && high_en)
        |=> (low_level != `DTG_LEVEL_MID) && (high_level != `DTG_LEVEL_MID))
        else $error("table load left one group silent");

    a_column_mutes_row: assert property (
        (eff_high[3] && (eff_high[2] ^ eff_high[1]) && !(eff_high == 4'he))
        || (eff_high == 4'hc) |-> !low_en)
        else $error("low tone not muted by high suppress code");

    a_test_code_source: assert property (
        test_sync_ff |-> (eff_low == low_pin_sync_ff) && (eff_high == high_pin_sync_ff))
        else $error("test mode not taking codes from the test ports");

    a_silent_idle: assert property (
        (!low_en && !high_en) [*3] |-> tone_level_ff == `DTG_TONE_IDLE)
        else $error("silent codes still produce tone");

    a_low_step_pick: assert property (
        (eff_low == 4'h8) |-> low_step == 12'(`DTG_STEP_CNT(`DTG_FREQ_L3_DHZ)))
        else $error("low code 1000 picks wrong divider");

    a_single_tone_only: assert property (
        (low_group_tone_select_ff == 4'h0) && high_valid && !test_sync_ff
        |-> high_en && !low_en)
        else $error("single tone selection not honoured");

    a_reset_silent: assert property (
        $rose(resetn) |-> (low_group_tone_select_ff == `DTG_LOW_RESET)
                          && (high_group_tone_select_ff == `DTG_HIGH_RESET))
        else $error("select registers not cleared by reset");

endmodule : dtg_generator

// file: core/dtg_defs.svh
// offsets, reset values and timing counts of the dual-tone dial generator
`ifndef DTG_DEFS_SVH
`define DTG_DEFS_SVH

// ****************************************
// port map
// ****************************************
`define DTG_ADDR_LOW        5'h01
`define DTG_ADDR_HIGH       5'h02
`define DTG_LOW_RESET       4'h0
`define DTG_HIGH_RESET      4'h0
`define DTG_RDATA_RESET     4'h0

// ****************************************
// waveform shape
// ****************************************
`define DTG_STEPS           32
`define DTG_LEVEL_MID       5'h0f
`define DTG_TONE_IDLE       6'h1e

// ****************************************
// clock (Hz) and tone frequencies (tenths of Hz)
// ****************************************
`define DTG_CLK_HZ          50000000
`define DTG_FREQ_L0_DHZ     7002
`define DTG_FREQ_L1_DHZ     7735
`define DTG_FREQ_L2_DHZ     8528
`define DTG_FREQ_L3_DHZ     9369
`define DTG_FREQ_H0_DHZ     12056
`define DTG_FREQ_H1_DHZ     13396
`define DTG_FREQ_H2_DHZ     14703
`define DTG_FREQ_H3_DHZ     16292

// ****************************************
// clocks per waveform step
// ****************************************
`define DTG_STEP_CNT(f)     ((`DTG_CLK_HZ * 10) / ((f) * `DTG_STEPS))

`endif

// file: core/dtg_pkg.sv
// types shared by the dual-tone dial generator
package dtg_pkg;

    typedef logic [3:0] dtg_code_type;
    typedef logic [4:0] dtg_addr_type;
    typedef logic [4:0] dtg_level_type;
    typedef logic [5:0] dtg_tone_type;
    typedef logic [11:0] dtg_count_type;

endpackage : dtg_pkg

// file: core/dtg_tone_osc.sv
// stepped quasi-sine oscillator for one tone group
`timescale 1ns/1ns
`include "dtg_defs.svh"

module dtg_tone_osc #(
    parameter bit LOW_AMP = 1'b0
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    // tone control
    input  wire logic              enable,
    input  wire dtg_pkg::dtg_count_type step_count,
    // waveform sample
    output dtg_pkg::dtg_level_type level_ff
);
    import dtg_pkg::*;

    // ****************************************
    // quarter-wave table
    // ****************************************
    localparam logic [3:0] QTR [8] = '{4'h1, 4'h4, 4'h7, 4'h9, 4'hb, 4'hd, 4'he, 4'he};

    dtg_count_type cnt_ff;
    logic [4:0]    phase_ff;
    logic          step_wrap;
    logic [2:0]    qidx;
    logic [3:0]    qval;
    logic [3:0]    mag;
    dtg_level_type nxt_level;

    assign step_wrap = (cnt_ff == step_count - 12'h001);

    // ****************************************
    // step divider
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 12'h000;
        end else if (!enable || step_wrap) begin
            cnt_ff <= 12'h000;
        end else begin
            cnt_ff <= cnt_ff + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= 5'h00;
        end else if (!enable) begin
            phase_ff <= 5'h00;
        end else if (step_wrap) begin
            phase_ff <= phase_ff + 5'h01;
        end
    end

    // ****************************************
    // sample shaping
    // ****************************************
    always_comb begin
        qidx = phase_ff[3] ? ~phase_ff[2:0] : phase_ff[2:0];
        qval = QTR[qidx];
        mag  = LOW_AMP ? (qval - {2'b00, qval[3:2]}) : qval;
        nxt_level = phase_ff[4] ? (`DTG_LEVEL_MID - {1'b0, mag})
                                : (`DTG_LEVEL_MID + {1'b0, mag});
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            level_ff <= `DTG_LEVEL_MID;
        end else begin
            level_ff <= enable ? nxt_level : `DTG_LEVEL_MID;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking osc_cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_step_advance: assert property (
        enable && $past(enable) && (phase_ff != $past(phase_ff))
        |-> $past(cnt_ff) == $past(step_count) - 12'h001)
        else $error("phase moved before its step count ran out");

    a_idle_mid_level: assert property (
        !enable |=> level_ff == `DTG_LEVEL_MID)
        else $error("disabled oscillator not at mid level");

endmodule : dtg_tone_osc

// file: bench/dtg_line_model.sv
// line circuit model: watches the summed tone sample on the tone output
`timescale 1ns/1ns

module dtg_line_model (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // observation control and tone input
    input  wire logic                  arm,
    input  wire dtg_pkg::dtg_tone_type tone_level,
    // measurements
    output int                         n_changes_ff,
    output int                         gap_ff,
    output int                         chk_ff
);
    import dtg_pkg::*;

    int           cyc_ff;
    int           t_first_ff;
    dtg_tone_type last_ff;

    // ****************************************
    // level change timing and waveform checksum
    // ****************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cyc_ff <= 0;
            n_changes_ff <= 0;
            chk_ff <= 0;
            gap_ff <= 0;
            t_first_ff <= 0;
            last_ff <= 6'h1e;
        end else begin
            cyc_ff <= cyc_ff + 1;
            last_ff <= tone_level;
            if (arm) begin
                n_changes_ff <= 0;
                chk_ff <= 0;
            end else begin
                chk_ff <= chk_ff * 31 + int'(tone_level);
                if (tone_level !== last_ff) begin
                    n_changes_ff <= n_changes_ff + 1;
                    if (n_changes_ff == 0) t_first_ff <= cyc_ff;
                    if (n_changes_ff == 1) gap_ff <= cyc_ff - t_first_ff;
                end
            end
        end
    end
endmodule : dtg_line_model

// file: bench/tb_top.sv
// self-checking bench of the dual-tone dial generator
`timescale 1ns/1ns

module tb_top;
    import dtg_pkg::*;

    logic         ref_clk = 1'b0;
    logic         resetn, port_wr, port_rd, tload, carry_flag, tone_test_mode, arm;
    logic         tone_active_ff;
    dtg_addr_type port_addr;
    dtg_code_type port_wdata, nib, tlow, thigh, port_rdata_ff;
    dtg_tone_type tone_level_ff;
    int           miscompares, n_tests, cycles, n_changes, gap, chk, chk_a;
    int           fl[4] = '{7002, 7735, 8528, 9369};
    int           fh[4] = '{12056, 13396, 14703, 16292};
    logic [7:0]   tbl[32] = '{8'h28, 8'h11, 8'h21, 8'h41, 8'h12, 8'h22, 8'h42, 8'h14,
                              8'h24, 8'h44, 8'h18, 8'h48, 8'h81, 8'h82, 8'h84, 8'h88,
                              8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                              8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    dtg_generator dtg_generator_inst (
        .ref_clk(ref_clk), .resetn(resetn), .port_addr(port_addr), .port_wr(port_wr),
        .port_rd(port_rd), .port_wdata(port_wdata), .port_rdata_ff(port_rdata_ff),
        .table_byte_to_tone_pair(tload), .carry_flag(carry_flag),
        .memory_pointer_pair_nibble(nib), .tone_test_mode(tone_test_mode),
        .test_low_code_port(tlow), .test_high_code_port(thigh),
        .tone_level_ff(tone_level_ff), .tone_active_ff(tone_active_ff));

    dtg_line_model dtg_line_model_inst (
        .ref_clk(ref_clk), .resetn(resetn), .arm(arm), .tone_level(tone_level_ff),
        .n_changes_ff(n_changes), .gap_ff(gap), .chk_ff(chk));

    always #10 ref_clk = ~ref_clk;

    // ****************************************
    // access and check tasks
    // ****************************************
    task check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", w, exp, seen);
        end
    endtask : check

    task wr(input dtg_addr_type a, input dtg_code_type d);
        @(negedge ref_clk);
        port_addr = a;
        port_wdata = d;
        port_wr = 1'b1;
        @(negedge ref_clk);
        port_wr = 1'b0;
    endtask : wr

    task rd(input dtg_addr_type a, input dtg_code_type e, input string w);
        @(negedge ref_clk);
        port_addr = a;
        port_rd = 1'b1;
        @(negedge ref_clk);
        port_rd = 1'b0;
        check(w, port_rdata_ff, e);
    endtask : rd

    task load(input logic [4:0] idx);
        @(negedge ref_clk);
        carry_flag = idx[4];
        nib = idx[3:0];
        tload = 1'b1;
        @(negedge ref_clk);
        tload = 1'b0;
    endtask : load

    task arm_line;
        @(negedge ref_clk);
        arm = 1'b1;
        @(negedge ref_clk);
        arm = 1'b0;
    endtask : arm_line

    task silent(input string w);
        repeat (4) @(negedge ref_clk);
        arm_line();
        repeat (300) @(negedge ref_clk);
        check({w, " changes"}, n_changes, 0);
        check({w, " active"}, tone_active_ff, 1'b0);
        check({w, " level"}, tone_level_ff, 6'h1e);
    endtask : silent

    task tone_gap(input dtg_addr_type a, input dtg_code_type c, input int dhz);
        int e;
        int k;
        e = 500000000 / (dhz * 32);
        wr(5'h01, 4'h0);
        wr(5'h02, 4'h0);
        repeat (4) @(negedge ref_clk);
        arm_line();
        wr(a, c);
        for (k = 0; k < 8000 && n_changes < 2; k++) @(negedge ref_clk);
        check("tone active", tone_active_ff, 1'b1);
        check("step length", (gap >= e - 1) && (gap <= e + 1), 1'b1);
    endtask : tone_gap

    task tally_and_finish;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        {port_wr, port_rd, tload, carry_flag, tone_test_mode, arm} = '0;
        port_addr = 5'h00;
        {port_wdata, nib, tlow, thigh} = '0;
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        check("reset level", tone_level_ff, 6'h1e);
        rd(5'h01, 4'h0, "reset low");
        rd(5'h02, 4'h0, "reset high");
        $display("done reset");
        wr(5'h01, 4'h5);
        wr(5'h02, 4'ha);
        wr(5'h03, 4'h7);
        rd(5'h01, 4'h5, "low rw");
        rd(5'h02, 4'ha, "high rw");
        rd(5'h03, 4'h0, "unmapped");
        @(negedge ref_clk);
        resetn = 1'b0;
        @(negedge ref_clk);
        resetn = 1'b1;
        rd(5'h01, 4'h0, "midrun reset");
        $display("done registers");
        for (int i = 0; i < 32; i++) begin
            load(5'(i));
            rd(5'h02, tbl[i][7:4], "table high");
            rd(5'h01, tbl[i][3:0], "table low");
        end
        $display("done table");
        for (int i = 0; i < 4; i++) begin
            tone_gap(5'h01, 4'h1 << i, fl[i]);
            tone_gap(5'h02, 4'h1 << i, fh[i]);
        end
        $display("done frequencies");
        for (int i = 10; i < 14; i++) begin
            wr(5'h02, 4'h0);
            wr(5'h01, 4'h1);
            wr(5'h02, 4'(i));
            silent("column suppress");
        end
        wr(5'h02, 4'h0);
        wr(5'h01, 4'h3);
        silent("two bits");
        wr(5'h01, 4'h0);
        silent("zero");
        $display("done suppression");
        arm_line();
        wr(5'h02, 4'h8);
        repeat (2000) @(negedge ref_clk);
        chk_a = chk;
        wr(5'h02, 4'h0);
        wr(5'h01, 4'h6);
        arm_line();
        wr(5'h02, 4'h8);
        repeat (2000) @(negedge ref_clk);
        check("single tone", chk, chk_a);
        wr(5'h01, 4'h0);
        wr(5'h02, 4'h0);
        arm_line();
        load(5'd12);
        @(negedge ref_clk);
        check("dual active", tone_active_ff, 1'b1);
        repeat (1997) @(negedge ref_clk);
        check("dual differs", chk != chk_a, 1'b1);
        $display("done dual tone");
        wr(5'h01, 4'h0);
        wr(5'h02, 4'h0);
        @(negedge ref_clk);
        tone_test_mode = 1'b1;
        tlow = 4'h1;
        thigh = 4'h2;
        repeat (6) @(negedge ref_clk);
        check("test mode active", tone_active_ff, 1'b1);
        rd(5'h01, 4'h0, "test mode reg");
        thigh = 4'hb;
        silent("test mode suppress");
        tone_test_mode = 1'b0;
        $display("done test mode");
        tally_and_finish();
    end
endmodule : tb_top
